// ===== design/bfs_consts.svh
// Constants of the buck fault sequencer: register map, field positions, reset values, timing.
// Assumes a 20 MHz hclk; the cycle counts of the times below are derived from each time in ns and that rate.
`ifndef BFS_CONSTS_SVH
`define BFS_CONSTS_SVH

`define BFS_CLK_MHZ 20
// Register byte offsets on the AHB-Lite slave.
`define BFS_CTRL_OFS 12'h000
`define BFS_STATUS_OFS 12'h004
`define BFS_PERIOD_OFS 12'h008
`define BFS_SYNC_MEAS_OFS 12'h00C
// Control register fields.
`define BFS_CTRL_SYNC_EN_BIT 0
`define BFS_CTRL_RESET 32'h0000_0000
// Internal switching period in hclk cycles (200 kHz at 20 MHz).
`define BFS_PERIOD_RESET 16'h0064
// Status register fields.
`define BFS_ST_STATE_LSB 0
`define BFS_ST_OV_BIT 4
`define BFS_ST_UV_BIT 5
`define BFS_ST_OC_BIT 6
`define BFS_ST_PG_BIT 7
`define BFS_ST_LOCK_BIT 8
`define BFS_ST_HANDOVER_BIT 9
// Reference in millivolts; soft-start, delay, filter and hiccup times in nanoseconds.
`define BFS_VREF_MV 800
`define BFS_SS_TIME_NS 5120000
`define BFS_SS_DELAY_NS 50000
`define BFS_PG_DELAY_NS 30000
`define BFS_OV_FILTER_NS 1000
`define BFS_HICCUP_NS 10240000
// Least times round up to whole cycles.
`define BFS_NS_TO_CYC(ns) ((((ns) * `BFS_CLK_MHZ) + 999) / 1000)
// Over-current cycle count before the slow threshold latches.
`define BFS_OC_CYCLES 4
// Synchronization window: the external period lies between 1/1.3 and 1 times the internal.
`define BFS_SYNC_NUM 10
`define BFS_SYNC_DEN 13

`endif

// ===== design/bfs_pkg.sv
// Types shared by the buck fault sequencer.
// Assumes the constants header for all numbers; this package holds types only.
package bfs_pkg;

    typedef enum logic [2:0] {
        BFS_POR,
        BFS_IDLE,
        BFS_SS_DELAY,
        BFS_SS_RAMP,
        BFS_RUN,
        BFS_HICCUP,
        BFS_FAULT
    } bfs_state_t;

    // Analogue comparator results and pins, each one bit, all asynchronous to hclk.
    typedef struct packed {
        logic vcc_ok;              // Control supply above its qualification threshold.
        logic vcclg_ok;            // Low-side driver supply above its qualification threshold.
        logic freq_set_enable_pin; // High while the enable pin is released.
        logic ov_hi;               // Output sense above 125 percent of reference.
        logic pre_ov_hi;           // Output sense above the pre-over-voltage threshold.
        logic discharge_lo;        // Output sense below 0.4 V.
        logic uv_lo;               // Output sense below 75 percent of reference.
        logic pg_hi;               // Output sense above reference plus ten percent.
        logic pg_lo;               // Output sense below reference minus ten percent.
        logic oc_th1;              // Current sense difference above 20 mV.
        logic oc_th2;              // Current sense difference above 30 mV.
        logic pwm_end;             // Modulator ramp crossed the error amplifier output.
        logic sync_input;          // External synchronization clock.
    } bfs_comp_t;

    typedef struct packed {
        logic ov;
        logic uv;
        logic oc;
    } bfs_fault_t;

endpackage

// ===== design/bfs_sequencer.sv
// Sequencing and protection supervisor of a single-phase synchronous buck controller.
// Assumes asynchronous comparator results, one AHB-Lite master, and a 20 MHz hclk.
//
// How it works
// - Hold in reset until both supplies qualify, then prepare switching.
// - Supplies dropping below qualification stop both gate outputs.
// - Soft-start begins by itself once supplies qualify and enable is released.
// - A rising ramp limits the feedback target; reference takes over above 0.8 V.
// - Soft-start waits a fixed delay before the ramp begins.
// - Power-good releases 30 us after the output stays within ten percent.
// - Power-good is driven low in soft-start, shutdown, over- or under-voltage.
// - Without input power, pull the error amplifier high, then enter hiccup.
// - High-side timing follows sync falling edges within 100 to 130 percent.
// - Output above 125 percent of reference triggers over-voltage; low-side gate high.
// - During over-voltage discharge the low-side gate drops once output falls below 0.4 V.
// - Over-voltage is latched and clears only by toggling a supply or enable.
// - Over-voltage must persist a fixed filter delay before it triggers.
// - With enable low, the low-side gate goes high above the pre-over-voltage level.
// - Pre-over-voltage does not latch; the low-side gate returns low at once.
// - Output below 75 percent of reference latches under-voltage; both gates low.
// - Under-voltage is ignored for the whole soft-start period.
// - Under-voltage clears and restarts only by toggling a supply or enable.
// - Current between 20 and 30 mV for four switching cycles latches both gates low.
// - Current above 30 mV latches both gates low at once.
//
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "bfs_consts.svh"

module bfs_sequencer #(
    parameter int SS_CYCLES = `BFS_NS_TO_CYC(`BFS_SS_TIME_NS),
    parameter int HICCUP_CYCLES = `BFS_NS_TO_CYC(`BFS_HICCUP_NS),
    parameter int OC_CYCLES = `BFS_OC_CYCLES
) (
    input wire logic hclk,                  // System clock, 20 MHz.
    input wire logic hresetn,               // Asynchronous reset, active low.
    input wire logic hsel,                  // AHB-Lite slave select.
    input wire logic [11:0] haddr,          // AHB-Lite byte address.
    input wire logic [1:0] htrans,          // AHB-Lite transfer type.
    input wire logic hwrite,                // AHB-Lite write strobe.
    input wire logic [2:0] hsize,           // AHB-Lite transfer size, word only.
    input wire logic hready,                // AHB-Lite bus ready.
    input wire logic [31:0] hwdata,         // AHB-Lite write data.
    output logic [31:0] hrdata,             // AHB-Lite read data.
    output logic hreadyout,                 // AHB-Lite slave ready.
    output logic hresp,                     // AHB-Lite response, always OKAY.
    input wire bfs_pkg::bfs_comp_t comp,    // Comparator results and pins.
    output logic high_side_gate,            // High-side gate command.
    output logic low_side_gate,             // Low-side gate command.
    input wire logic power_good_in,         // Level seen on the power-good pin.
    output logic power_good_out,            // Power-good pin drive value, always low.
    output logic power_good_oe_n,           // Power-good drive enable, low while pulling low.
    output logic comp_pull_high,            // Pulls the error amplifier output high.
    output logic [9:0] ss_target_mv,        // Feedback target clamp in millivolts.
    output logic ref_handover               // Fixed reference owns the loop.
);

    localparam int CW = $bits(bfs_pkg::bfs_comp_t);
    localparam int PG_CYCLES = `BFS_NS_TO_CYC(`BFS_PG_DELAY_NS);
    localparam int DELAY_CYCLES = `BFS_NS_TO_CYC(`BFS_SS_DELAY_NS);
    localparam int OVF_CYCLES = `BFS_NS_TO_CYC(`BFS_OV_FILTER_NS);
    localparam int STEP_CYCLES = SS_CYCLES / `BFS_VREF_MV;
    localparam logic [9:0] VREF_MV = 10'(`BFS_VREF_MV);

    // Two-flop synchronizers on every comparator, one per bit.
    logic [CW-1:0] meta_q;
    logic [CW-1:0] sync_q;
    bfs_pkg::bfs_comp_t cs;
    genvar gi;
    generate
        for (gi = 0; gi < CW; gi++)
        begin : g_sync
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    meta_q[gi] <= 1'b0;
                    sync_q[gi] <= 1'b0;
                end
                else
                begin
                    meta_q[gi] <= comp[gi];
                    sync_q[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate
    assign cs = bfs_pkg::bfs_comp_t'(sync_q);

    logic por_ok;
    logic en_ok;
    logic live;
    assign por_ok = cs.vcc_ok & cs.vcclg_ok;
    assign en_ok = cs.freq_set_enable_pin;
    // Dropping either supply or the enable is the only way out of a latched fault.
    assign live = por_ok & en_ok;

    // Register file.
    logic [31:0] ctrl_q;
    logic [15:0] period_q;
    logic [15:0] sync_meas_q;
    logic wr_pend_q;
    logic [11:0] wr_addr_q;
    logic [31:0] rdata_q;
    logic [31:0] status;
    logic addr_ph;
    bfs_pkg::bfs_state_t state_q;
    bfs_pkg::bfs_fault_t fault_q;
    logic pg_q;
    logic lock_q;
    logic [9:0] ramp_q;

    assign addr_ph = hsel & hready & htrans[1];
    assign status = {22'h00_0000, ref_handover, lock_q, pg_q, fault_q.oc, fault_q.uv,
                     fault_q.ov, 1'b0, 3'(state_q)};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_q <= addr_ph & hwrite;
            if (addr_ph)
            begin
                wr_addr_q <= haddr;
            end
            if (addr_ph && !hwrite)
            begin
                case (haddr)
                    `BFS_CTRL_OFS: rdata_q <= ctrl_q;
                    `BFS_STATUS_OFS: rdata_q <= status;
                    `BFS_PERIOD_OFS: rdata_q <= {16'h0000, period_q};
                    `BFS_SYNC_MEAS_OFS: rdata_q <= {16'h0000, sync_meas_q};
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_q <= `BFS_CTRL_RESET;
            period_q <= `BFS_PERIOD_RESET;
        end
        else if (wr_pend_q)
        begin
            if (wr_addr_q == `BFS_CTRL_OFS)
            begin
                ctrl_q <= {31'h0000_0000, hwdata[`BFS_CTRL_SYNC_EN_BIT]};
            end
            if (wr_addr_q == `BFS_PERIOD_OFS)
            begin
                period_q <= hwdata[15:0];
            end
        end
    end

    assign hrdata = rdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Switching cycle: internal oscillator, or falling edges of a qualified sync clock.
    logic [15:0] osc_q;
    logic [15:0] since_q;
    logic sync_prev_q;
    logic sync_fall;
    logic osc_tick;
    logic cyc_start;
    logic in_window;
    assign sync_fall = sync_prev_q & ~cs.sync_input;
    assign osc_tick = (osc_q >= period_q - 16'h0001);
    assign in_window = (32'(since_q) * `BFS_SYNC_DEN >= 32'(period_q) * `BFS_SYNC_NUM)
                       && (since_q <= period_q);
    assign cyc_start = lock_q ? sync_fall : osc_tick;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            osc_q <= 16'h0000;
            since_q <= 16'h0000;
            sync_prev_q <= 1'b0;
            sync_meas_q <= 16'h0000;
            lock_q <= 1'b0;
        end
        else
        begin
            sync_prev_q <= cs.sync_input;
            osc_q <= osc_tick ? 16'h0000 : osc_q + 16'h0001;
            if (sync_fall)
            begin
                since_q <= 16'h0001;
                sync_meas_q <= since_q;
                lock_q <= ctrl_q[`BFS_CTRL_SYNC_EN_BIT] & in_window;
            end
            else
            begin
                if (since_q != 16'hFFFF)
                begin
                    since_q <= since_q + 16'h0001;
                end
                // A missing edge or a disabled sync drops back to the oscillator.
                if (since_q > period_q || !ctrl_q[`BFS_CTRL_SYNC_EN_BIT])
                begin
                    lock_q <= 1'b0;
                end
            end
        end
    end

    // Sequencer.
    logic [31:0] tmr_q;
    logic ss_done;
    logic ss_active;
    assign ss_done = (ramp_q > VREF_MV);
    assign ss_active = (state_q == bfs_pkg::BFS_SS_DELAY) || (state_q == bfs_pkg::BFS_SS_RAMP);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= bfs_pkg::BFS_POR;
            tmr_q <= 32'h0000_0000;
            ramp_q <= 10'h000;
        end
        else if (!por_ok)
        begin
            state_q <= bfs_pkg::BFS_POR;
            tmr_q <= 32'h0000_0000;
            ramp_q <= 10'h000;
        end
        else if (!en_ok)
        begin
            state_q <= bfs_pkg::BFS_IDLE;
            tmr_q <= 32'h0000_0000;
            ramp_q <= 10'h000;
        end
        else if (|fault_q)
        begin
            state_q <= bfs_pkg::BFS_FAULT;
        end
        else
        begin
            tmr_q <= tmr_q + 32'h0000_0001;
            case (state_q)
                bfs_pkg::BFS_POR,
                bfs_pkg::BFS_IDLE:
                begin
                    state_q <= bfs_pkg::BFS_SS_DELAY;
                    tmr_q <= 32'h0000_0000;
                end
                bfs_pkg::BFS_SS_DELAY:
                begin
                    if (tmr_q >= 32'(DELAY_CYCLES - 1))
                    begin
                        state_q <= bfs_pkg::BFS_SS_RAMP;
                        tmr_q <= 32'h0000_0000;
                    end
                end
                bfs_pkg::BFS_SS_RAMP:
                begin
                    if (tmr_q >= 32'(STEP_CYCLES - 1))
                    begin
                        tmr_q <= 32'h0000_0000;
                        ramp_q <= ramp_q + 10'h001;
                    end
                    if (ss_done)
                    begin
                        tmr_q <= 32'h0000_0000;
                        // Output never came up: no input power, so retry later.
                        state_q <= cs.uv_lo ? bfs_pkg::BFS_HICCUP : bfs_pkg::BFS_RUN;
                    end
                end
                bfs_pkg::BFS_HICCUP:
                begin
                    ramp_q <= 10'h000;
                    if (tmr_q >= 32'(HICCUP_CYCLES - 1))
                    begin
                        state_q <= bfs_pkg::BFS_SS_DELAY;
                        tmr_q <= 32'h0000_0000;
                    end
                end
                bfs_pkg::BFS_RUN:
                begin
                    tmr_q <= 32'h0000_0000;
                end
                bfs_pkg::BFS_FAULT:
                begin
                    tmr_q <= 32'h0000_0000;
                end
                default:
                begin
                    state_q <= bfs_pkg::BFS_POR;
                end
            endcase
        end
    end

    assign ss_target_mv = ss_done ? VREF_MV : ramp_q;
    assign ref_handover = ss_done;

    // Protection latches.
    logic [7:0] ovf_q;
    logic [3:0] oc_cnt_q;
    logic oc_cyc_q;
    logic prot_on;
    assign prot_on = ss_active || (state_q == bfs_pkg::BFS_RUN);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ovf_q <= 8'h00;
        end
        else if (cs.ov_hi && prot_on)
        begin
            ovf_q <= (ovf_q == 8'(OVF_CYCLES)) ? ovf_q : ovf_q + 8'h01;
        end
        else
        begin
            ovf_q <= 8'h00;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            oc_cnt_q <= 4'h0;
            oc_cyc_q <= 1'b0;
        end
        else if (!prot_on)
        begin
            oc_cnt_q <= 4'h0;
            oc_cyc_q <= 1'b0;
        end
        else if (cyc_start)
        begin
            // A cycle counts only if the slow threshold held across all of it.
            oc_cnt_q <= (oc_cyc_q && cs.oc_th1) ? oc_cnt_q + 4'h1 : 4'h0;
            oc_cyc_q <= cs.oc_th1;
        end
        else if (!cs.oc_th1)
        begin
            oc_cyc_q <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fault_q <= '0;
        end
        else if (!live)
        begin
            fault_q <= '0;
        end
        else
        begin
            if (ovf_q == 8'(OVF_CYCLES))
            begin
                fault_q.ov <= 1'b1;
            end
            if (cs.uv_lo && state_q == bfs_pkg::BFS_RUN)
            begin
                fault_q.uv <= 1'b1;
            end
            if (prot_on && (cs.oc_th2 || oc_cnt_q >= 4'(OC_CYCLES)))
            begin
                fault_q.oc <= 1'b1;
            end
        end
    end

    // Gate commands, fault overrides first.
    logic pwm_on_q;
    logic hs_d;
    logic ls_d;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pwm_on_q <= 1'b0;
        end
        else if (cyc_start)
        begin
            pwm_on_q <= 1'b1;
        end
        else if (cs.pwm_end)
        begin
            pwm_on_q <= 1'b0;
        end
    end

    always_comb
    begin
        hs_d = 1'b0;
        ls_d = 1'b0;
        if (!por_ok)
        begin
            hs_d = 1'b0;
            ls_d = 1'b0;
        end
        else if (fault_q.ov)
        begin
            ls_d = ~cs.discharge_lo;
        end
        else if (fault_q.uv || fault_q.oc)
        begin
            ls_d = 1'b0;
        end
        else if (!en_ok)
        begin
            ls_d = cs.pre_ov_hi;
        end
        else if (state_q == bfs_pkg::BFS_SS_RAMP || state_q == bfs_pkg::BFS_RUN)
        begin
            hs_d = pwm_on_q;
            ls_d = ~pwm_on_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            high_side_gate <= 1'b0;
            low_side_gate <= 1'b0;
            comp_pull_high <= 1'b0;
        end
        else
        begin
            high_side_gate <= hs_d;
            low_side_gate <= ls_d;
            comp_pull_high <= (state_q == bfs_pkg::BFS_SS_RAMP) && cs.uv_lo;
        end
    end

    // Power good.
    logic [15:0] pg_cnt_q;
    logic pg_win;
    assign pg_win = ~cs.pg_hi & ~cs.pg_lo;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pg_cnt_q <= 16'h0000;
            pg_q <= 1'b0;
        end
        else if (state_q != bfs_pkg::BFS_RUN || fault_q.ov || fault_q.uv || !pg_win)
        begin
            pg_cnt_q <= 16'h0000;
            pg_q <= 1'b0;
        end
        else if (pg_cnt_q >= 16'(PG_CYCLES - 1))
        begin
            pg_q <= 1'b1;
        end
        else
        begin
            pg_cnt_q <= pg_cnt_q + 16'h0001;
        end
    end

    assign power_good_out = 1'b0;
    assign power_good_oe_n = pg_q;

    default clocking dc @(posedge hclk); endclocking
    default disable iff (!hresetn);

    oc_fast_latch_a: assert property (live && prot_on && cs.oc_th2 |=> fault_q.oc ##1
        (!high_side_gate && !low_side_gate)) else $error("fast over-current not latched");
    oc_count_a: assert property ($rose(fault_q.oc) && !$past(cs.oc_th2)
        |-> $past(oc_cnt_q) >= 4'(OC_CYCLES)) else $error("slow over-current latched early");
    uv_gates_a: assert property (fault_q.uv |=> !high_side_gate && !low_side_gate)
        else $error("gates active during under-voltage");
    uv_ignore_ss_a: assert property (ss_active && live |=> !$rose(fault_q.uv))
        else $error("under-voltage seen in soft-start");
    ov_filter_a: assert property ($rose(fault_q.ov) |-> $past(cs.ov_hi, 2))
        else $error("over-voltage without filtered cause");
    ov_hold_a: assert property (fault_q.ov && live |=> fault_q.ov)
        else $error("over-voltage latch released");
    ov_discharge_a: assert property (por_ok && fault_q.ov && !cs.discharge_lo
        |=> low_side_gate && !high_side_gate) else $error("no over-voltage discharge");
    ov_stop_a: assert property (fault_q.ov && cs.discharge_lo |=> !low_side_gate)
        else $error("discharge continued below 0.4 V");
    preov_follow_a: assert property (por_ok && !en_ok && !(|fault_q)
        |=> low_side_gate == $past(cs.pre_ov_hi)) else $error("pre-over-voltage mismatch");
    pg_low_a: assert property (ss_active || state_q == bfs_pkg::BFS_IDLE
        |=> !power_good_oe_n) else $error("power-good released out of run");
    pg_delay_a: assert property ($rose(pg_q) |-> $past(pg_cnt_q) == 16'(PG_CYCLES - 1))
        else $error("power-good delay wrong");
    por_gates_a: assert property (!por_ok |=> !high_side_gate && !low_side_gate)
        else $error("gates switch without supplies");
    handover_a: assert property (state_q == bfs_pkg::BFS_RUN |-> ref_handover)
        else $error("run before reference handover");

    ss_cover_c: cover property (state_q == bfs_pkg::BFS_SS_RAMP ##1 state_q == bfs_pkg::BFS_RUN);
    pg_cover_c: cover property ($rose(pg_q));
    oc_cover_c: cover property ($rose(fault_q.oc) && oc_cnt_q >= 4'(OC_CYCLES));
    hiccup_cover_c: cover property (state_q == bfs_pkg::BFS_HICCUP);
    lock_cover_c: cover property ($rose(lock_q));

endmodule // bfs_sequencer
`default_nettype wire

// ===== dv/bfs_stage_model.sv
// Power stage and system enable as seen by the sequencer's comparators.
// Assumes the bench sets sensed levels in cmd; cycle ends and sync come from here.
`timescale 1ns/1ps
`default_nettype none
module bfs_stage_model (
    input wire logic hclk, // System clock.
    input wire bfs_pkg::bfs_comp_t cmd, // Levels set by the bench.
    input wire logic sync_on, // Runs the external sync clock.
    output var bfs_pkg::bfs_comp_t comp // Levels seen by the sequencer.
);
    logic [6:0] cyc_q = 7'h00;
    always_ff @(posedge hclk)
    begin
        cyc_q <= (cyc_q == 7'h63) ? 7'h00 : cyc_q + 7'h01;
    end
    // Sync period equals the 100 cycle internal period, the upper end of the window.
    always_comb
    begin
        comp = cmd;
        comp.pwm_end = (cyc_q == 7'h31);
        comp.sync_input = sync_on && (cyc_q < 7'h2D);
    end
endmodule // bfs_stage_model
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for the buck fault sequencer: registers, start-up, protections.
// Assumes the stage model feeds the comparators and the bench is the only bus master.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic hclk, hresetn, hsel, hwrite, sync_on, hreadyout, hresp, high_side_gate, low_side_gate;
    logic power_good_out, power_good_oe_n, comp_pull_high, ref_handover;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic [9:0] ss_target_mv;
    bfs_pkg::bfs_comp_t cmd, comp;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e;} bfs_row_t;
    bfs_row_t rows [5] = '{'{1'h0, 12'h000, 32'h0, 32'h0}, '{1'h0, 12'h008, 32'h0, 32'h64},
        '{1'h1, 12'h000, 32'h1, 32'h0}, '{1'h0, 12'h000, 32'h0, 32'h1},
        '{1'h0, 12'h010, 32'h0, 32'h0}};
    bfs_stage_model bfs_stage_model_i (.hclk, .cmd, .sync_on, .comp);
    // Short soft-start and hiccup keep the run to a few thousand cycles.
    bfs_sequencer #(.SS_CYCLES(1600), .HICCUP_CYCLES(200)) bfs_sequencer_i (.hclk, .hresetn,
        .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata,
        .hreadyout, .hresp, .comp, .high_side_gate, .low_side_gate,
        .power_good_in(power_good_oe_n), .power_good_out, .power_good_oe_n, .comp_pull_high,
        .ss_target_mv, .ref_handover);
    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    initial
    begin
        {hsel, hwrite, sync_on, hresetn, haddr, htrans, hwdata} = '0;
        hsize = 3'h2;
        cmd = '0;
        step(4);
        chk("reset outputs", 5'h00, {high_side_gate, low_side_gate, power_good_oe_n, hresp,
            power_good_out});
        hresetn <= 1'b1;
        step(1);
        foreach (rows[i])
        begin
            ahb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w)
                chk("register read", rows[i].e, rd);
        end
        $display("register test done");
        {cmd.vcc_ok, cmd.vcclg_ok, cmd.freq_set_enable_pin} <= 3'h7;
        step(20);
        ahb(1'b0, 12'h004, 32'h0);
        chk("soft start state", 3'h2, rd[2:0]);
        chk("power good in soft start", 1'h0, power_good_oe_n);
        cmd.oc_th2 <= 1'b1;
        step(2);
        cmd.oc_th2 <= 1'b0;
        step(8);
        ahb(1'b0, 12'h004, 32'h0);
        chk("fast over current", 6'h38, {rd[6], rd[2:0], high_side_gate, low_side_gate});
        cmd.freq_set_enable_pin <= 1'b0;
        step(6);
        ahb(1'b0, 12'h004, 32'h0);
        chk("fault cleared by enable", 1'h0, rd[6]);
        cmd.pre_ov_hi <= 1'b1;
        step(8);
        chk("pre over voltage on", 1'h1, low_side_gate);
        cmd.pre_ov_hi <= 1'b0;
        step(8);
        chk("pre over voltage off", 1'h0, low_side_gate);
        $display("over current and pre over voltage tests done");
        cmd.freq_set_enable_pin <= 1'b1;
        step(20);
        // Four whole periods cannot pass within 300 cycles, but always within 550.
        cmd.oc_th1 <= 1'b1;
        step(300);
        ahb(1'b0, 12'h004, 32'h0);
        chk("slow over current early", 1'h0, rd[6]);
        step(250);
        ahb(1'b0, 12'h004, 32'h0);
        chk("slow over current", 1'h1, rd[6]);
        {cmd.oc_th1, cmd.freq_set_enable_pin} <= 2'h0;
        step(6);
        cmd.freq_set_enable_pin <= 1'b1;
        step(20);
        cmd.ov_hi <= 1'b1;
        step(10);
        cmd.ov_hi <= 1'b0;
        step(8);
        chk("over voltage glitch", 1'h0, low_side_gate);
        cmd.ov_hi <= 1'b1;
        step(40);
        chk("over voltage discharge", 1'h1, low_side_gate);
        cmd.ov_hi <= 1'b0;
        step(8);
        ahb(1'b0, 12'h004, 32'h0);
        chk("over voltage latched", 2'h3, {rd[4], low_side_gate});
        cmd.discharge_lo <= 1'b1;
        step(8);
        chk("discharge stops", 1'h0, low_side_gate);
        cmd.vcc_ok <= 1'b0;
        step(8);
        ahb(1'b0, 12'h004, 32'h0);
        chk("supply drop", 3'h0, {rd[4], high_side_gate, low_side_gate});
        $display("over voltage test done");
        cmd.discharge_lo <= 1'b0;
        cmd.vcc_ok <= 1'b1;
        step(3700);
        ahb(1'b0, 12'h004, 32'h0);
        chk("run after ramp", 5'h13, {rd[2:0], ref_handover, power_good_oe_n});
        chk("target clamp", 10'h320, ss_target_mv);
        sync_on <= 1'b1;
        step(300);
        ahb(1'b0, 12'h004, 32'h0);
        chk("sync lock", 1'h1, rd[8]);
        ahb(1'b0, 12'h00C, 32'h0);
        chk("sync period", 32'h0000_0064, rd);
        cmd.uv_lo <= 1'b1;
        step(8);
        ahb(1'b0, 12'h004, 32'h0);
        chk("under voltage", 4'h8, {rd[5], high_side_gate, low_side_gate, power_good_oe_n});
        $display("run and under voltage test done");
        // The output stays low, so the ramp must end in hiccup instead of run.
        cmd.freq_set_enable_pin <= 1'b0;
        step(6);
        cmd.freq_set_enable_pin <= 1'b1;
        step(1800);
        chk("pull high without input", 1'h1, comp_pull_high);
        step(850);
        ahb(1'b0, 12'h004, 32'h0);
        chk("hiccup", 3'h5, rd[2:0]);
        $display("hiccup test done");
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
